// [src/cst_byte_shift.sv]
// spi mode 0 byte shifter, msb first both ways
module cst_byte_shift (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic rise_in,
   input wire logic fall_in,
   input wire logic cs_act_in,
   input wire logic mosi_in,
   input wire logic [7:0] tx_byte_in,
   output logic miso_out,
   output logic [7:0] rx_byte_out,
   output logic rx_valid_out,
   output logic tx_take_out
);
   logic [2:0] bit_cnt_reg;
   logic [6:0] rx_sh_reg;
   logic [7:0] tx_sh_reg;
   assign miso_out = tx_sh_reg[7];
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         bit_cnt_reg <= 3'h0;
         rx_sh_reg <= 7'h00;
      end else if (!cs_act_in) begin
         bit_cnt_reg <= 3'h0;
      end else if (rise_in) begin
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         rx_sh_reg <= {rx_sh_reg[5:0], mosi_in};
      end
   end
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_byte_out <= 8'hff;
         rx_valid_out <= 1'b0;
      end else begin
         rx_valid_out <= cs_act_in && rise_in && (bit_cnt_reg == 3'h7);
         if (cs_act_in && rise_in && (bit_cnt_reg == 3'h7)) begin
            rx_byte_out <= {rx_sh_reg, mosi_in};
         end
      end
   end
   // next byte is fetched on the fall after the eighth rise
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tx_sh_reg <= 8'hff;
         tx_take_out <= 1'b0;
      end else begin
         tx_take_out <= cs_act_in && fall_in && (bit_cnt_reg == 3'h0);
         if (!cs_act_in) begin
            tx_sh_reg <= 8'hff;
         end else if (fall_in && (bit_cnt_reg == 3'h0)) begin
            tx_sh_reg <= tx_byte_in;
         end else if (fall_in) begin
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b1};
         end
      end
   end
endmodule

// [src/cst_card_spi_tokens.sv]
// card spi reply and data token engine with ahb-lite registers
// Summary of operation
// [RULE1] all bytes travel msb first
// [RULE2] short status after every non-query command
// [RULE3] seven short status flags, one means set
// [RULE4] busy bytes zero while busy, then nonzero
// [RULE5] query status gives two bytes, short first
// [RULE6] one bit: out of range or protected field
// [RULE7] second byte flags erase, protect, ecc, controller, general
// [RULE8] one bit: protected erase skip or lock failure
// [RULE9] locked bit follows card lock state
// [RULE10] operating conditions reply: status plus four bytes
// [RULE11] data ack status 010, 101 or 110
// [RULE12] data token: start, data, two crc bytes
// [RULE13] start fe or fc, stop fd
// [RULE14] written blocks are exactly 512 bytes
// [RULE15] host reads never cross block boundary
// [RULE16] host writes never cross block boundary
// [RULE17] protect token: 32 bits lsb first group, crc
// [RULE18] read failure sends one byte error token
// [RULE19] error bits clear once sent to host
// [RULE20] state bits follow card state
// [RULE21] execution errors only in extended reply
// [RULE22] no underrun or overrun bits reported
// [RULE23] host keeps clock running after replies
// [RULE24] short status bit order idle upward
// [RULE25] ack byte: bit4 zero, status, bit0 one
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
module cst_card_spi_tokens (
   input wire logic CORE_CLK_IN,
   input wire logic RESET_IN,
   input wire logic HSEL_IN,
   input wire logic [cst_pkg::DATA_W-1:0] HADDR_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic [2:0] HSIZE_IN,
   input wire logic [cst_pkg::DATA_W-1:0] HWDATA_IN,
   input wire logic HREADY_IN,
   output logic [cst_pkg::DATA_W-1:0] HRDATA_OUT,
   output logic HREADYOUT_OUT,
   output logic HRESP_OUT,
   input wire logic SPI_SCK_IN,
   input wire logic SPI_CS_N_IN,
   input wire logic SPI_MOSI_IN,
   output logic SPI_MISO_OUT,
   output logic SPI_MISO_OE_OUT
);
   import cst_pkg::*;
   logic sck_s;
   logic cs_n_s;
   logic mosi_s;
   logic sck_d_reg;
   logic rise;
   logic fall;
   logic cs_act;
   logic [7:0] rx_byte;
   logic rx_valid;
   logic tx_take;
   logic [7:0] tx_byte;
   logic acc;
   logic wr_pend_reg;
   logic [AW-1:0] wr_addr_reg;
   logic wr;
   logic rd_rx;
   logic [31:0] rd_mux;
   logic [31:0] ocr_reg;
   logic busy_reg;
   logic [31:0] wp_reg;
   logic [15:0] wpcrc_reg;
   logic [5:0] wpcnt_reg;
   logic [1:0] state_reg;
   logic [2:0] ack_reg;
   logic rx_arm_reg;
   logic [6:1] short_err_reg;
   logic [7:1] ext_err_reg;
   logic [6:1] evt_short;
   logic [7:1] evt_ext;
   logic [6:1] clr_short;
   logic [7:1] clr_ext;
   logic [7:0] short_now;
   logic [7:0] ext_now;
   logic [7:0] snap_short_reg;
   logic [7:0] snap_ext_reg;
   logic [31:0] wp_masked;
   cst_kind_type kind_wr;
   cst_kind_type kind_reg;
   cst_seq_type seq_reg;
   logic [2:0] idx_reg;
   logic [2:0] last_idx;
   logic start;
   cst_rx_type rx_state_reg;
   logic [9:0] rx_cnt_reg;
   logic [7:0] rx_data_reg;
   logic rx_new_reg;
   logic blk_done_reg;
   logic stop_seen_reg;
   logic [15:0] rx_crc_reg;

   // pins from the host cross into the core clock
   cst_sync3 u_sync_sck (
      .clk_in(CORE_CLK_IN),
      .rst_in(RESET_IN),
      .d_in(SPI_SCK_IN),
      .q_out(sck_s)
   );
   cst_sync3 u_sync_cs (
      .clk_in(CORE_CLK_IN),
      .rst_in(RESET_IN),
      .d_in(SPI_CS_N_IN),
      .q_out(cs_n_s)
   );
   cst_sync3 u_sync_mosi (
      .clk_in(CORE_CLK_IN),
      .rst_in(RESET_IN),
      .d_in(SPI_MOSI_IN),
      .q_out(mosi_s)
   );
   always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         sck_d_reg <= 1'b1; // matches the synchroniser, so no false rise after reset
      end else begin
         sck_d_reg <= sck_s;
      end
   end
   assign rise = sck_s && !sck_d_reg;
   assign fall = !sck_s && sck_d_reg;
   assign cs_act = !cs_n_s;
   assign SPI_MISO_OE_OUT = cs_act;

   cst_byte_shift u_shift (
      .clk_in(CORE_CLK_IN),
      .rst_in(RESET_IN),
      .rise_in(rise),
      .fall_in(fall),
      .cs_act_in(cs_act),
      .mosi_in(mosi_s),
      .tx_byte_in(tx_byte), // RULE1
      .miso_out(SPI_MISO_OUT),
      .rx_byte_out(rx_byte),
      .rx_valid_out(rx_valid),
      .tx_take_out(tx_take)
   );

   // bus slave: zero wait states, always okay
   assign HREADYOUT_OUT = 1'b1;
   assign HRESP_OUT = 1'b0;
   assign acc = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
   assign wr = wr_pend_reg;
   assign rd_rx = acc && !HWRITE_IN && (HADDR_IN[AW-1:0] == ADDR_RX);
   always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= '0;
      end else begin
         wr_pend_reg <= acc && HWRITE_IN;
         if (acc) begin
            wr_addr_reg <= HADDR_IN[AW-1:0];
         end
      end
   end
   always_comb begin
      case (HADDR_IN[AW-1:0])
         ADDR_CTRL: rd_mux = {23'h0, rx_arm_reg, 1'b0, ack_reg,
                              seq_reg != SEQ_IDLE, kind_reg};
         ADDR_OCR: rd_mux = ocr_reg;
         ADDR_BUSY: rd_mux = {31'h0, busy_reg};
         ADDR_WP: rd_mux = wp_reg;
         ADDR_WPCRC: rd_mux = {16'h0, wpcrc_reg};
         ADDR_WPCNT: rd_mux = {26'h0, wpcnt_reg};
         ADDR_STATE: rd_mux = {30'h0, state_reg};
         ADDR_RX: rd_mux = {rx_crc_reg, 4'h0, rx_state_reg == RX_DATA,
                            stop_seen_reg, blk_done_reg, rx_new_reg, rx_data_reg};
         ADDR_FLAGS: rd_mux = {16'h0, ext_now, short_now};
         default: rd_mux = 32'h0;
      endcase
   end
   // read data is prepared in the address phase
   always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         HRDATA_OUT <= 32'h0;
      end else if (acc && !HWRITE_IN) begin
         HRDATA_OUT <= rd_mux;
      end
   end

   // configuration written by card firmware
   always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         ocr_reg <= OCR_RESET;
         busy_reg <= 1'b0;
         wp_reg <= 32'h0;
         wpcrc_reg <= 16'h0;
         wpcnt_reg <= WP_GROUPS;
         state_reg <= STATE_RESET;
         ack_reg <= ACK_RESET;
         rx_arm_reg <= 1'b0;
      end else if (wr) begin
         case (wr_addr_reg)
            ADDR_CTRL: begin
               ack_reg <= HWDATA_IN[CTRL_ACK_LSB +: 3];
               rx_arm_reg <= HWDATA_IN[CTRL_ARM_BIT];
            end
            ADDR_OCR: ocr_reg <= HWDATA_IN;
            ADDR_BUSY: busy_reg <= HWDATA_IN[0];
            ADDR_WP: wp_reg <= HWDATA_IN;
            ADDR_WPCRC: wpcrc_reg <= HWDATA_IN[15:0];
            ADDR_WPCNT: wpcnt_reg <= HWDATA_IN[5:0];
            ADDR_STATE: state_reg <= HWDATA_IN[1:0]; // RULE20
            default: ;
         endcase
      end
   end

   // error flags: sticky, set beats a clear in the same cycle
   assign evt_short = (wr && wr_addr_reg == ADDR_EVENT) ? HWDATA_IN[6:1] : 6'h0;
   assign evt_ext = (wr && wr_addr_reg == ADDR_EVENT) ?
                    HWDATA_IN[EVT_EXT_LSB+1 +: 7] : 7'h0;
   always_comb begin
      clr_short = 6'h0;
      clr_ext = 7'h0;
      if (start) begin
         if (kind_wr inside {KIND_SHORT, KIND_BUSY, KIND_EXT, KIND_OPCOND}) begin
            clr_short = 6'h3f; // RULE19
         end
         if (kind_wr == KIND_EXT) begin
            clr_ext = 7'h7f; // RULE19
         end
         if (kind_wr == KIND_DERR) begin
            clr_ext = 7'h4e; // RULE19
         end
      end
   end
   always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         short_err_reg <= 6'h0;
         ext_err_reg <= 7'h0;
      end else begin
         short_err_reg <= (short_err_reg & ~clr_short) | evt_short;
         ext_err_reg <= (ext_err_reg & ~clr_ext) | evt_ext;
      end
   end
   // no underrun or overrun positions exist anywhere
   assign short_now = {1'b0, short_err_reg, state_reg[ST_IDLE_BIT]}; // RULE2 RULE3 RULE24 RULE22
   assign ext_now = {ext_err_reg, state_reg[ST_LOCK_BIT]}; // RULE6 RULE7 RULE8 RULE9

   // groups past the valid range read as zero
   assign wp_masked = (wpcnt_reg >= WP_GROUPS) ? wp_reg :
                      (wp_reg & ((32'h1 << wpcnt_reg) - 32'h1)); // RULE17

   // reply sequencer; a start while busy is ignored
   assign kind_wr = cst_kind_type'(HWDATA_IN[2:0]);
   assign start = wr && (wr_addr_reg == ADDR_CTRL) && (kind_wr != KIND_NONE)
                  && (seq_reg == SEQ_IDLE);
   always_comb begin
      case (kind_reg)
         KIND_EXT: last_idx = 3'h1; // RULE5
         KIND_OPCOND: last_idx = 3'h4; // RULE10
         KIND_WP: last_idx = 3'h6; // RULE12
         default: last_idx = 3'h0;
      endcase
   end
   always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         snap_short_reg <= 8'h0;
         snap_ext_reg <= 8'h0;
         kind_reg <= KIND_NONE;
      end else if (start) begin
         snap_short_reg <= short_now;
         snap_ext_reg <= ext_now;
         kind_reg <= kind_wr;
      end
   end
   always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         seq_reg <= SEQ_IDLE;
         idx_reg <= 3'h0;
      end else begin
         case (seq_reg)
            SEQ_IDLE: begin
               idx_reg <= 3'h0;
               if (start) begin
                  seq_reg <= SEQ_SEND;
               end
            end
            SEQ_SEND: begin
               if (tx_take && idx_reg == last_idx) begin
                  seq_reg <= (kind_reg == KIND_BUSY) ? SEQ_BUSY : SEQ_IDLE; // RULE4
               end else if (tx_take) begin
                  idx_reg <= idx_reg + 3'h1;
               end
            end
            SEQ_BUSY: begin
               if (tx_take && !busy_reg) begin
                  seq_reg <= SEQ_IDLE; // RULE4
               end
            end
            default: seq_reg <= SEQ_IDLE;
         endcase
      end
   end
   // byte offered to the shifter at each byte boundary
   always_comb begin
      tx_byte = BYTE_IDLE;
      if (seq_reg == SEQ_BUSY) begin
         tx_byte = busy_reg ? BUSY_BYTE : BYTE_IDLE; // RULE4
      end else if (seq_reg == SEQ_SEND) begin
         case (kind_reg)
            KIND_SHORT, KIND_BUSY: tx_byte = snap_short_reg; // RULE2
            KIND_EXT: tx_byte = (idx_reg == 3'h0) ? snap_short_reg : snap_ext_reg; // RULE5
            KIND_OPCOND: begin
               case (idx_reg)
                  3'h0: tx_byte = snap_short_reg;
                  3'h1: tx_byte = ocr_reg[31:24]; // RULE10
                  3'h2: tx_byte = ocr_reg[23:16];
                  3'h3: tx_byte = ocr_reg[15:8];
                  default: tx_byte = ocr_reg[7:0];
               endcase
            end
            KIND_ACK: tx_byte = {3'h7, 1'b0, ack_reg, 1'b1}; // RULE11 RULE25
            KIND_DERR: tx_byte = {4'h0, snap_ext_reg[EB_OOR], snap_ext_reg[EB_ECC],
                                  snap_ext_reg[EB_CC], snap_ext_reg[EB_ERR]}; // RULE18
            KIND_WP: begin
               case (idx_reg)
                  3'h0: tx_byte = TOK_START; // RULE13
                  3'h1: tx_byte = wp_masked[31:24]; // RULE17
                  3'h2: tx_byte = wp_masked[23:16];
                  3'h3: tx_byte = wp_masked[15:8];
                  3'h4: tx_byte = wp_masked[7:0];
                  3'h5: tx_byte = wpcrc_reg[15:8]; // RULE12
                  default: tx_byte = wpcrc_reg[7:0];
               endcase
            end
            default: tx_byte = BYTE_IDLE;
         endcase
      end
   end

   // write block receiver; boundaries are the host's concern
   always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         rx_state_reg <= RX_HUNT;
         rx_cnt_reg <= 10'h0;
         rx_crc_reg <= 16'h0;
      end else if (rx_valid) begin
         case (rx_state_reg)
            RX_HUNT: begin
               rx_cnt_reg <= 10'h0;
               if (rx_arm_reg && (rx_byte == TOK_START || rx_byte == TOK_START_MULTI)) begin
                  rx_state_reg <= RX_DATA; // RULE13
               end
            end
            RX_DATA: begin
               rx_cnt_reg <= rx_cnt_reg + 10'h1;
               if (rx_cnt_reg == BLOCK_BYTES) begin
                  rx_crc_reg[15:8] <= rx_byte; // RULE12
               end
               if (rx_cnt_reg == RX_LAST) begin
                  rx_crc_reg[7:0] <= rx_byte;
                  rx_state_reg <= RX_HUNT; // RULE14 RULE16
               end
            end
            default: rx_state_reg <= RX_HUNT;
         endcase
      end
   end
   // status flags of the receiver clear on read of rx word
   always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         rx_data_reg <= 8'h0;
         rx_new_reg <= 1'b0;
         blk_done_reg <= 1'b0;
         stop_seen_reg <= 1'b0;
      end else begin
         if (rx_valid && rx_state_reg == RX_DATA && rx_cnt_reg < BLOCK_BYTES) begin
            rx_data_reg <= rx_byte;
            rx_new_reg <= 1'b1;
         end else if (rd_rx) begin
            rx_new_reg <= 1'b0;
         end
         if (rx_valid && rx_state_reg == RX_DATA && rx_cnt_reg == RX_LAST) begin
            blk_done_reg <= 1'b1; // RULE14
         end else if (rd_rx) begin
            blk_done_reg <= 1'b0;
         end
         if (rx_valid && rx_state_reg == RX_HUNT && rx_arm_reg && rx_byte == TOK_STOP) begin
            stop_seen_reg <= 1'b1; // RULE13
         end else if (rd_rx) begin
            stop_seen_reg <= 1'b0;
         end
      end
   end

   short_msb_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (seq_reg == SEQ_SEND && idx_reg == 3'h0
       && kind_reg inside {KIND_SHORT, KIND_BUSY, KIND_EXT, KIND_OPCOND}) |-> !tx_byte[7])
      else $error("short status msb not zero"); // RULE2
   ack_format_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (seq_reg == SEQ_SEND && kind_reg == KIND_ACK) |->
      (!tx_byte[4] && tx_byte[0] && tx_byte[3:1] == ack_reg))
      else $error("ack byte layout wrong"); // RULE25
   ext_first_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      start && kind_wr == KIND_EXT |=> (tx_byte == snap_short_reg)
      && (snap_short_reg == $past(short_now)))
      else $error("extended reply first byte differs"); // RULE5
   opcond_len_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (seq_reg == SEQ_SEND && kind_reg == KIND_OPCOND && idx_reg == 3'h4 && tx_take)
      |=> seq_reg == SEQ_IDLE)
      else $error("operating conditions reply not five bytes"); // RULE10
   busy_zero_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (seq_reg == SEQ_BUSY) |-> (tx_byte == 8'h00) == busy_reg)
      else $error("busy byte does not follow busy state"); // RULE4
   clear_read_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (start && kind_wr == KIND_SHORT && !evt_short[SB_CRC]) |=> !short_err_reg[SB_CRC])
      else $error("sent error bit not cleared"); // RULE19
   set_wins_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      evt_ext[EB_ECC] |=> ext_err_reg[EB_ECC])
      else $error("error event lost"); // RULE7
   lock_bit_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      start |=> snap_ext_reg[EB_LOCKED] == $past(state_reg[ST_LOCK_BIT]))
      else $error("locked bit not state"); // RULE9
   derr_low_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (seq_reg == SEQ_SEND && kind_reg == KIND_DERR) |->
      (tx_byte[7:4] == 4'h0 && tx_byte[0] == snap_ext_reg[EB_ERR]))
      else $error("error token bits wrong"); // RULE18
   wp_mask_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (wpcnt_reg < WP_GROUPS) |-> ((wp_masked >> wpcnt_reg) == 32'h0))
      else $error("out of range group not zero"); // RULE17
   block_end_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (rx_valid && rx_state_reg == RX_DATA && rx_cnt_reg == RX_LAST)
      |=> blk_done_reg && rx_state_reg == RX_HUNT)
      else $error("block of 512 plus crc not closed"); // RULE14
endmodule

// [src/cst_pkg.sv]
// constants and types for the card spi token block
package cst_pkg;
   localparam int DATA_W = 32;
   localparam int AW = 8;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_EVENT = 8'h04;
   localparam logic [7:0] ADDR_OCR = 8'h08;
   localparam logic [7:0] ADDR_BUSY = 8'h0c;
   localparam logic [7:0] ADDR_WP = 8'h10;
   localparam logic [7:0] ADDR_WPCRC = 8'h14;
   localparam logic [7:0] ADDR_WPCNT = 8'h18;
   localparam logic [7:0] ADDR_STATE = 8'h1c;
   localparam logic [7:0] ADDR_RX = 8'h20;
   localparam logic [7:0] ADDR_FLAGS = 8'h24;
   localparam int CTRL_ACK_LSB = 4;
   localparam int CTRL_ACTIVE_BIT = 3;
   localparam int CTRL_ARM_BIT = 8;
   localparam int EVT_EXT_LSB = 8;
   localparam int ST_IDLE_BIT = 0;
   localparam int ST_LOCK_BIT = 1;
   localparam logic [1:0] STATE_RESET = 2'h1;
   localparam logic [31:0] OCR_RESET = 32'h0000_0000;
   localparam logic [2:0] ACK_RESET = 3'h2;
   localparam logic [7:0] TOK_START = 8'hfe;
   localparam logic [7:0] TOK_START_MULTI = 8'hfc;
   localparam logic [7:0] TOK_STOP = 8'hfd;
   localparam logic [7:0] BYTE_IDLE = 8'hff;
   localparam logic [7:0] BUSY_BYTE = 8'h00;
   localparam logic [2:0] ACK_OK = 3'h2;
   localparam logic [2:0] ACK_CRC = 3'h5;
   localparam logic [2:0] ACK_WRITE = 3'h6;
   localparam logic [9:0] BLOCK_BYTES = 10'h200;
   localparam logic [9:0] RX_LAST = 10'h201;
   localparam logic [5:0] WP_GROUPS = 6'h20;
   // short status bit positions
   localparam int SB_IDLE = 0;
   localparam int SB_ERESET = 1;
   localparam int SB_ILLEGAL = 2;
   localparam int SB_CRC = 3;
   localparam int SB_ESEQ = 4;
   localparam int SB_ADDR = 5;
   localparam int SB_PARAM = 6;
   // extended second byte bit positions
   localparam int EB_LOCKED = 0;
   localparam int EB_SKIP = 1;
   localparam int EB_ERR = 2;
   localparam int EB_CC = 3;
   localparam int EB_ECC = 4;
   localparam int EB_WPV = 5;
   localparam int EB_EPARAM = 6;
   localparam int EB_OOR = 7;
   typedef enum logic [2:0] {
      KIND_NONE = 3'h0,
      KIND_SHORT = 3'h1,
      KIND_BUSY = 3'h2,
      KIND_EXT = 3'h3,
      KIND_OPCOND = 3'h4,
      KIND_ACK = 3'h5,
      KIND_DERR = 3'h6,
      KIND_WP = 3'h7
   } cst_kind_type;
   typedef enum logic [2:0] {
      SEQ_IDLE = 3'h1,
      SEQ_SEND = 3'h2,
      SEQ_BUSY = 3'h4
   } cst_seq_type;
   typedef enum logic [1:0] {
      RX_HUNT = 2'h1,
      RX_DATA = 2'h2
   } cst_rx_type;
endpackage

// [src/cst_sync3.sv]
// three flop synchroniser with agreement filter
module cst_sync3 (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic d_in,
   output logic q_out
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
      end else begin
         s1_reg <= d_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end
   // change counts only once stages two and three agree
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         q_out <= 1'b1;
      end else if (s2_reg == s3_reg) begin
         q_out <= s3_reg;
      end
   end
endmodule

// [verification/cst_card_spi_tokens_tb.sv]
// bench for the card spi token block
module cst_card_spi_tokens_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import cst_pkg::*;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] c; int n; logic [55:0] e;}
      cst_row_type;
   logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic hready, hresp, sck, cs_n, mosi, miso, miso_oe;
   logic [7:0] b;
   wire logic line = miso_oe ? miso : 1'b1;
   int miscompares = 0, checked = 0;
   cst_row_type rows [12] = '{
      '{ADDR_EVENT, 32'h4, 32'h1, 1, 56'h05},
      '{ADDR_EVENT, 32'h0, 32'h1, 1, 56'h01},
      '{ADDR_EVENT, 32'h8040, 32'h3, 2, 56'h4180},
      '{ADDR_OCR, 32'h12345678, 32'h4, 5, 56'h0112345678},
      '{ADDR_EVENT, 32'h0, 32'h25, 1, 56'he5},
      '{ADDR_EVENT, 32'h0, 32'h55, 1, 56'heb},
      '{ADDR_EVENT, 32'h0, 32'h65, 1, 56'hed},
      '{ADDR_EVENT, 32'h1400, 32'h6, 1, 56'h05},
      '{ADDR_EVENT, 32'h7a00, 32'h3, 2, 56'h017a},
      '{ADDR_WP, 32'ha5c30f81, 32'h7, 7, 56'hfea5c30f811234},
      '{ADDR_WPCNT, 32'h8, 32'h7, 7, 56'hfe000000811234},
      '{ADDR_STATE, 32'h2, 32'h3, 2, 56'h0001}};
   always #50 clk = !clk;
   cst_card_spi_tokens dut_u (.CORE_CLK_IN(clk), .RESET_IN(rst), .HSEL_IN(hsel),
      .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize),
      .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
      .HRESP_OUT(hresp), .SPI_SCK_IN(sck), .SPI_CS_N_IN(cs_n), .SPI_MOSI_IN(mosi),
      .SPI_MISO_OUT(miso), .SPI_MISO_OE_OUT(miso_oe));
   cst_host_model host_u (.sck_out(sck), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(line));
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic complete_run;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic edge_rdy;
      int n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 64);
      if (n >= 64) begin
         miscompares++;
         complete_run();
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      hsize <= 3'h2;
      edge_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hsize <= 3'h0;
      hwdata <= wd;
      edge_rdy();
      rd = hrdata;
   endtask
   task automatic reply(input logic [31:0] c, input int n, input logic [55:0] e);
      host_u.select(1'b1);
      check("oe", miso_oe, 32'h1);
      ahb(1'b1, ADDR_CTRL, c);
      host_u.xfer(8'hff, b);
      check("lead", b, 32'hff);
      for (int i = 0; i < n; i++) begin
         host_u.xfer(8'hff, b);
         check("reply", b, e[8*(n-1-i)+:8]);
      end
      host_u.xfer(8'hff, b);
      check("idle", b, 32'hff);
      host_u.select(1'b0);
   endtask
   initial begin
      #9000000;
      miscompares++;
      complete_run();
   end
   initial begin
      repeat (2) @(posedge clk);
      check("rst oe", miso_oe, 32'h0);
      check("rst rd", hrdata, 32'h0);
      rst <= 1'b0;
      ahb(1'b0, ADDR_STATE, 32'h0);
      check("state", rd, 32'h1);
      ahb(1'b0, 8'h3c, 32'h0);
      check("unmapped", rd, 32'h0);
      check("resp", hresp, 32'h0);
      ahb(1'b1, ADDR_WPCRC, 32'h1234);
      foreach (rows[i]) begin
         ahb(1'b1, rows[i].a, rows[i].d);
         reply(rows[i].c, rows[i].n, rows[i].e);
      end
      ahb(1'b1, ADDR_BUSY, 32'h1);
      host_u.select(1'b1);
      ahb(1'b1, ADDR_CTRL, 32'h2);
      host_u.xfer(8'hff, b);
      host_u.xfer(8'hff, b);
      check("busy short", b, 32'h0);
      host_u.xfer(8'hff, b);
      check("busy", b, BUSY_BYTE);
      ahb(1'b1, ADDR_BUSY, 32'h0);
      for (int i = 0; i < 3 && b === 8'h00; i++) host_u.xfer(8'hff, b);
      check("ready", b, 32'hff);
      ahb(1'b1, ADDR_CTRL, 32'h100);
      host_u.xfer(TOK_START_MULTI, b);
      for (int i = 0; i < 514; i++) host_u.xfer(i < 512 ? i[7:0] : (i == 512 ? 8'hbe : 8'hef), b);
      host_u.select(1'b0);
      ahb(1'b0, ADDR_RX, 32'h0);
      check("block", rd & 32'hffff0200, 32'hbeef0200);
      host_u.select(1'b1);
      host_u.xfer(TOK_STOP, b);
      host_u.select(1'b0);
      ahb(1'b0, ADDR_RX, 32'h0);
      check("stop", rd & 32'h600, 32'h400);
      // second reset in mid-run: locked state must fall back to idle
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      check("rst2 oe", miso_oe, 32'h0);
      check("rst2 rd", hrdata, 32'h0);
      rst <= 1'b0;
      ahb(1'b0, ADDR_STATE, 32'h0);
      check("state2", rd, 32'h1);
      complete_run();
   end
endmodule

// [verification/cst_host_model.sv]
// spi host partner model, mode 0, clock still between frames
module cst_host_model (
   output logic sck_out,
   output logic cs_n_out,
   output logic mosi_out,
   input wire logic miso_in
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      sck_out = 1'b0;
      cs_n_out = 1'b1;
      mosi_out = 1'b1;
   end
   task automatic select(input logic on);
      #800;
      cs_n_out = !on;
      #800;
   endtask
   // long low phase: miso settles through the card's synchroniser first
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         mosi_out = tx[i];
         #575;
         sck_out = 1'b1;
         rx[i] = miso_in;
         #225;
         sck_out = 1'b0;
      end
      mosi_out = !tx[0];
   endtask
endmodule
